// >>> src/owm_cfg.svh
// timing, threshold and field constants for the one-wire motion block
`ifndef OWM_CFG_SVH
`define OWM_CFG_SVH
// ---------------------------------------------------------------
// clock and timebase
// ---------------------------------------------------------------
`define OWM_CLK_NS 10
`define OWM_TICK_NS 500
`define OWM_TICK_CYC (`OWM_TICK_NS / `OWM_CLK_NS)
// ---------------------------------------------------------------
// default phase times in microseconds, debounce in samples
// ---------------------------------------------------------------
`define OWM_BOOT_PULSE_US 1000
`define OWM_WINDOW_US 10000
`define OWM_MOT_PULSE_US 1000
`define OWM_HIB_DELAY_US 1000
`define OWM_DEBOUNCE_SAMPLES 1
// ---------------------------------------------------------------
// selection pulse widths in microseconds
// ---------------------------------------------------------------
`define OWM_SEL1_MIN_US 562.5
`define OWM_SEL1_MAX_US 883
`define OWM_SEL2_MIN_US 1125
`define OWM_SEL2_MAX_US 1570
`define OWM_SEL3_MIN_US 2250
`define OWM_SEL3_MAX_US 2950
// ---------------------------------------------------------------
// upper threshold counts, lower is the negative; field widths in bits
// ---------------------------------------------------------------
`define OWM_THR_DEF 64
`define OWM_THR_ONE 32
`define OWM_THR_TWO 96
`define OWM_THR_THREE 128
`define OWM_SAMPLE_W 12
`define OWM_TIMER_W 24
`define OWM_WIDTH_W 16
`endif

// >>> src/owm_motion_top.sv
// one-wire motion detection and boot/hibernate sequencer
// Notes on behaviour
// RQ1: deep-sleep request enters hibernate; chip-select ignored (code: ignored only with strap high; strap low, a chip-select rise boots)
// RQ2: boot enables line input and indicator output
// RQ3: boot drives indicator low for boot time
// RQ4: line and indicator share one wired-AND pull-up
// RQ5: line low at boot end: hibernate, await rise
// RQ6: line rising wakes device into new boot
// RQ7: host may send one selection low pulse
// RQ8: no pulse in window gives default threshold
// RQ9: both pulse edges must lie inside window
// RQ10: out-of-range width falls back to default
// RQ11: width ranges per selection one, two, three
// RQ12: upper thresholds 32, 96, 128 counts
// RQ13: lower threshold is negated upper threshold
// RQ14: compare raw counts, mg only informative
// RQ15: compare every sample while detection runs; samples during a motion pulse are skipped
// RQ16: threshold and debounce met: motion low pulse
// RQ17: host register traffic leaves protocol undisturbed
// RQ18: host holds line low to force hibernate
// RQ19: hibernate only after line low entry delay
// RQ20: active set automatically after boot, line high
// RQ21: active clears on hibernate entry or host clear
// RQ22: window and width timed by oscillator ticks
// RQ23: line released except during our low pulses
`timescale 1ns/1ps
`include "owm_cfg.svh"
module owm_motion_top import owm_pkg::*; #(
  parameter int BOOT_PULSE_US = `OWM_BOOT_PULSE_US,
  parameter int WINDOW_US = `OWM_WINDOW_US,
  parameter int MOT_PULSE_US = `OWM_MOT_PULSE_US,
  parameter int HIB_DELAY_US = `OWM_HIB_DELAY_US,
  parameter int DEBOUNCE = `OWM_DEBOUNCE_SAMPLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // motion line pin, open drain
  input wire logic motionLineIn,
  output logic motionLineOut,
  output logic motionLineOe_n,
  // strap and wake pins
  input wire logic bootStrapSelect,
  input wire logic csWakeIn,
  // register-side controls
  input wire logic deepSleepReq,
  input wire logic activeSet,
  input wire logic activeClr,
  // sample stream
  input wire logic sampleValid,
  input wire logic signed [11:0] sampleVal,
  // status
  output logic active,
  output logic hibernating,
  output logic lineInEnable,
  output logic bootOutEnable,
  output owm_sel_e thrSelect,
  output logic signed [11:0] upperThr,
  output logic signed [11:0] lowerThr
);
  // ---------------------------------------------------------------
  // timing in ticks
  // ---------------------------------------------------------------
  localparam int TW = `OWM_TIMER_W;
  localparam int BOOT_TK = (BOOT_PULSE_US * 1000) / `OWM_TICK_NS;
  localparam int WIN_TK = (WINDOW_US * 1000) / `OWM_TICK_NS;
  localparam int MOT_TK = (MOT_PULSE_US * 1000) / `OWM_TICK_NS;
  localparam int HIB_TK = (HIB_DELAY_US * 1000) / `OWM_TICK_NS;
  localparam int PRE_W = $clog2(`OWM_TICK_CYC);

  generate
    if (BOOT_TK < 1 || WIN_TK < 1 || MOT_TK < 1 || HIB_TK < 1) begin : g_chk_t
      $error("owm_motion_top: phase times must be at least one tick");
    end
    if (BOOT_TK >= 2**TW || WIN_TK >= 2**TW || MOT_TK >= 2**TW || HIB_TK >= 2**TW) begin : g_chk_w
      $error("owm_motion_top: phase time exceeds timer width");
    end
    if (DEBOUNCE < 1 || DEBOUNCE > 255) begin : g_chk_d
      $error("owm_motion_top: DEBOUNCE must be 1 to 255");
    end
    if (WIN_TK < 2 || `OWM_TICK_CYC < 2) begin : g_chk_win
      $error("owm_motion_top: window needs two ticks and a tick two cycles");
    end
  endgenerate

  typedef struct packed {
    owm_state_e state;
    logic [PRE_W-1:0] pre;
    logic [TW-1:0] tmr;
    logic [TW-1:0] hibCnt;
    logic [TW-1:0] motTmr;
    logic [7:0] deb;
    logic strap;
    logic active;
    logic drive;
    logic lineHiPrev;
    logic wakePrev;
    owm_sel_e sel;
  } owm_top_s;

  owm_top_s top_r;
  owm_top_s top_nxt;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pinSync;
  logic lineHi;
  logic strapSync;
  logic wakeSync;

  owm_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({csWakeIn, bootStrapSelect, motionLineIn}),
    .syncOut(pinSync)
  );

  assign lineHi = pinSync[0];
  assign strapSync = pinSync[1];
  assign wakeSync = pinSync[2];

  // ---------------------------------------------------------------
  // selection pulse measurement
  // ---------------------------------------------------------------
  logic tick;
  logic windowOpen;
  owm_sel_e measSel;

  assign tick = (top_r.pre == PRE_W'(`OWM_TICK_CYC - 1));
  assign windowOpen = (top_r.state == OWM_ST_SELECT) || (top_r.state == OWM_ST_BCHK && top_r.strap); // [RQ9]

  owm_pulse_meas u_meas (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .windowOpen(windowOpen),
    .lineHi(lineHi),
    .selResult(measSel),
    .selDone()
  );

  // ---------------------------------------------------------------
  // threshold lookup
  // ---------------------------------------------------------------
  function automatic logic signed [11:0] upperOf(input owm_sel_e s);
    logic signed [11:0] v;
    v = 12'(`OWM_THR_DEF); // [RQ8]
    case (s)
      OWM_SEL_ONE: v = 12'(`OWM_THR_ONE); // [RQ12]
      OWM_SEL_TWO: v = 12'(`OWM_THR_TWO);
      OWM_SEL_THREE: v = 12'(`OWM_THR_THREE);
      default: v = 12'(`OWM_THR_DEF);
    endcase
    return v;
  endfunction

  logic signed [11:0] upNow;
  logic signed [11:0] loNow;
  logic exceed;

  assign upNow = upperOf(top_r.sel);
  assign loNow = -upperOf(top_r.sel); // [RQ13]
  assign exceed = (sampleVal > upNow) || (sampleVal < loNow); // [RQ14]

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    top_nxt = top_r;
    top_nxt.pre = tick ? '0 : top_r.pre + PRE_W'(1);
    top_nxt.lineHiPrev = lineHi;
    top_nxt.wakePrev = wakeSync;
    case (top_r.state)
      OWM_ST_BOOT: begin
        top_nxt.drive = 1'b1; // [RQ3] [RQ4]
        top_nxt.strap = strapSync;
        top_nxt.active = 1'b0;
        if (tick) begin
          if (top_r.tmr >= TW'(BOOT_TK - 1)) begin
            top_nxt.tmr = '0;
            top_nxt.drive = 1'b0; // [RQ23]
            top_nxt.state = OWM_ST_BCHK;
          end else begin
            top_nxt.tmr = top_r.tmr + TW'(1);
          end
        end
      end
      OWM_ST_BCHK: begin
        if (tick) begin
          top_nxt.tmr = '0;
          top_nxt.sel = OWM_SEL_DEF;
          if (!top_r.strap) begin
            top_nxt.state = OWM_ST_RUN;
          end else if (lineHi) begin
            top_nxt.active = 1'b1; // [RQ20]
            top_nxt.tmr = TW'(1); // [RQ9]
            top_nxt.state = OWM_ST_SELECT;
          end else begin
            top_nxt.state = OWM_ST_HIB; // [RQ5]
          end
        end
      end
      OWM_ST_HIB: begin
        top_nxt.active = 1'b0;
        top_nxt.drive = 1'b0;
        top_nxt.tmr = '0;
        if (top_r.strap) begin
          if (lineHi && !top_r.lineHiPrev) begin
            top_nxt.state = OWM_ST_BOOT; // [RQ5] [RQ6]
          end
        end else if (wakeSync && !top_r.wakePrev) begin
          top_nxt.state = OWM_ST_BOOT;
        end
      end
      OWM_ST_SELECT: begin
        if (tick) begin
          if (top_r.tmr >= TW'(WIN_TK - 1)) begin
            top_nxt.sel = measSel; // [RQ8] [RQ10]
            top_nxt.tmr = '0;
            top_nxt.hibCnt = '0;
            top_nxt.deb = '0;
            top_nxt.state = OWM_ST_RUN;
          end else begin
            top_nxt.tmr = top_r.tmr + TW'(1); // [RQ22]
          end
        end
      end
      OWM_ST_RUN: begin
        if (activeSet) begin
          top_nxt.active = 1'b1;
        end else if (activeClr) begin
          top_nxt.active = 1'b0; // [RQ21]
        end
        if (top_r.drive) begin
          if (tick) begin
            if (top_r.motTmr >= TW'(MOT_TK - 1)) begin
              top_nxt.drive = 1'b0; // [RQ23]
              top_nxt.motTmr = '0;
            end else begin
              top_nxt.motTmr = top_r.motTmr + TW'(1);
            end
          end
        end else if (top_r.active && sampleValid) begin // [RQ15]
          if (!exceed) begin
            top_nxt.deb = '0;
          end else if (top_r.deb >= 8'(DEBOUNCE - 1)) begin
            top_nxt.deb = '0;
            top_nxt.drive = 1'b1; // [RQ16]
            top_nxt.motTmr = '0;
          end else begin
            top_nxt.deb = top_r.deb + 8'h01;
          end
        end
        if (top_r.strap && !top_r.drive && !lineHi) begin // [RQ18]
          if (tick) begin
            top_nxt.hibCnt = top_r.hibCnt + TW'(1);
          end
        end else begin
          top_nxt.hibCnt = '0;
        end
        if (deepSleepReq) begin
          top_nxt.state = OWM_ST_HIB; // [RQ1]
          top_nxt.active = 1'b0;
          top_nxt.drive = 1'b0;
        end else if (top_r.strap && top_r.hibCnt >= TW'(HIB_TK)) begin
          top_nxt.state = OWM_ST_HIB; // [RQ19]
          top_nxt.active = 1'b0; // [RQ21]
          top_nxt.drive = 1'b0;
        end
      end
      default: begin
        top_nxt.state = OWM_ST_BOOT;
        top_nxt.drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      top_r <= '0;
      top_r.state <= OWM_ST_BOOT;
    end else begin
      top_r <= top_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign motionLineOut = 1'b0;
  assign motionLineOe_n = ~top_r.drive; // [RQ23]
  assign active = top_r.active;
  assign hibernating = (top_r.state == OWM_ST_HIB);
  assign lineInEnable = 1'b1; // [RQ2] [RQ5]
  assign bootOutEnable = top_r.strap || (top_r.state == OWM_ST_BOOT); // [RQ2]
  assign thrSelect = top_r.sel;
  assign upperThr = upNow;
  assign lowerThr = loNow;
endmodule // owm_motion_top

// >>> src/owm_pkg.sv
// shared types of the one-wire motion block
package owm_pkg;
  typedef enum logic [4:0] {
    OWM_ST_BOOT   = 5'b0_0001,
    OWM_ST_BCHK   = 5'b0_0010,
    OWM_ST_HIB    = 5'b0_0100,
    OWM_ST_SELECT = 5'b0_1000,
    OWM_ST_RUN    = 5'b1_0000
  } owm_state_e;

  typedef enum logic [1:0] {
    OWM_SEL_DEF   = 2'h0,
    OWM_SEL_ONE   = 2'h1,
    OWM_SEL_TWO   = 2'h2,
    OWM_SEL_THREE = 2'h3
  } owm_sel_e;

  typedef struct packed {
    logic armed;
    logic low;
    logic [15:0] width;
    logic done;
    owm_sel_e sel;
  } owm_meas_s;
endpackage

// >>> src/owm_pulse_meas.sv
// selection pulse width measurement and classification
`timescale 1ns/1ps
`include "owm_cfg.svh"
module owm_pulse_meas import owm_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // timebase and window
  input wire logic tick,
  input wire logic windowOpen,
  // synchronised line level
  input wire logic lineHi,
  // result
  output owm_sel_e selResult,
  output logic selDone
);
  localparam int MIN1 = int'($ceil(`OWM_SEL1_MIN_US * 1000.0 / `OWM_TICK_NS));
  localparam int MAX1 = int'($floor(`OWM_SEL1_MAX_US * 1000.0 / `OWM_TICK_NS));
  localparam int MIN2 = int'($ceil(`OWM_SEL2_MIN_US * 1000.0 / `OWM_TICK_NS));
  localparam int MAX2 = int'($floor(`OWM_SEL2_MAX_US * 1000.0 / `OWM_TICK_NS));
  localparam int MIN3 = int'($ceil(`OWM_SEL3_MIN_US * 1000.0 / `OWM_TICK_NS));
  localparam int MAX3 = int'($floor(`OWM_SEL3_MAX_US * 1000.0 / `OWM_TICK_NS));

  owm_meas_s meas_r;
  owm_meas_s meas_nxt;

  // ---------------------------------------------------------------
  // width to selection
  // ---------------------------------------------------------------
  function automatic owm_sel_e classify(input logic [15:0] w);
    owm_sel_e s;
    s = OWM_SEL_DEF; // [RQ10]
    if (w >= 16'(MIN1) && w <= 16'(MAX1)) begin // [RQ11]
      s = OWM_SEL_ONE;
    end else if (w >= 16'(MIN2) && w <= 16'(MAX2)) begin
      s = OWM_SEL_TWO;
    end else if (w >= 16'(MIN3) && w <= 16'(MAX3)) begin
      s = OWM_SEL_THREE;
    end
    return s;
  endfunction

  // ---------------------------------------------------------------
  // measurement
  // ---------------------------------------------------------------
  always_comb begin
    meas_nxt = meas_r;
    if (!windowOpen) begin
      meas_nxt = '0; // [RQ8]
    end else if (!meas_r.done) begin
      if (!meas_r.armed) begin
        meas_nxt.armed = lineHi; // [RQ9]
      end else if (!meas_r.low && !lineHi) begin
        meas_nxt.low = 1'b1; // [RQ7]
        meas_nxt.width = '0;
      end else if (meas_r.low && !lineHi) begin
        if (tick && meas_r.width != 16'hFFFF) begin // [RQ22]
          meas_nxt.width = meas_r.width + 16'h0001;
        end
      end else if (meas_r.low && lineHi) begin
        meas_nxt.done = 1'b1; // [RQ9]
        meas_nxt.sel = classify(meas_r.width);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meas_r <= '0;
    end else begin
      meas_r <= meas_nxt;
    end
  end

  assign selResult = meas_r.sel;
  assign selDone = meas_r.done;
endmodule // owm_pulse_meas

// >>> src/owm_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module owm_sync import owm_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } owm_sync_s;

  owm_sync_s sync_r;
  owm_sync_s sync_nxt;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("owm_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_comb begin
    sync_nxt.stage1 = asyncIn;
    sync_nxt.stage2 = sync_r.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r.stage2;
endmodule // owm_sync

// >>> test/owm_host_model.sv
// host microcontroller model on the shared motion line
`timescale 1ns/1ps
module owm_host_model (
  // clock
  input wire logic sys_clk,
  // device open-drain enable
  input wire logic devOe_n,
  // resolved line level
  output logic lineLevel
);
  logic pullupEn = 1'b0;
  logic hostLow = 1'b0;
  // wired-AND; with pull-up off the host pin holds the line low
  assign lineLevel = pullupEn && !hostLow && devOe_n;
  // wake, then one selection pulse after boot indicator release
  task automatic sel_pulse(input int widthUs);
    int n;
    n = 0;
    @(posedge sys_clk) #1 pullupEn = 1'b1;
    while (devOe_n && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    while (!devOe_n && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (1000) @(posedge sys_clk);
    #1 hostLow = 1'b1;
    repeat (widthUs * 100) @(posedge sys_clk);
    #1 hostLow = 1'b0;
  endtask
  // pull the line low or release it
  task automatic drive_low(input logic lo);
    @(posedge sys_clk) #1 hostLow = lo;
  endtask
endmodule // owm_host_model

// >>> test/owm_motion_top_assertions.sv
// concurrent checks of the one-wire motion block
`timescale 1ns/1ps
module owm_motion_top_assertions import owm_pkg::*; #(
  parameter int BOOT_PULSE_US = 1000,
  parameter int WINDOW_US = 10000,
  parameter int MOT_PULSE_US = 1000,
  parameter int HIB_DELAY_US = 1000,
  parameter int DEBOUNCE = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins
  input wire logic motionLineIn,
  input wire logic motionLineOut,
  input wire logic motionLineOe_n,
  input wire logic bootStrapSelect,
  // controls and samples
  input wire logic deepSleepReq,
  input wire logic sampleValid,
  input wire logic signed [11:0] sampleVal,
  // status
  input wire logic active,
  input wire logic hibernating,
  input wire logic lineInEnable,
  input wire logic bootOutEnable,
  input wire owm_sel_e thrSelect,
  input wire logic signed [11:0] upperThr,
  input wire logic signed [11:0] lowerThr
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  localparam int BOOT_CYC = BOOT_PULSE_US * 100;
  localparam int MOT_CYC = MOT_PULSE_US * 100;
  localparam int HIB_CYC = HIB_DELAY_US * 100;
  logic [23:0] oeLowCnt;
  logic [23:0] lineLowCnt;
  logic exceedNow;
  assign exceedNow = sampleValid && (sampleVal > upperThr || sampleVal < lowerThr);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oeLowCnt <= 24'h00_0000;
      lineLowCnt <= 24'h00_0000;
    end else begin
      oeLowCnt <= motionLineOe_n ? 24'h00_0000 : oeLowCnt + 24'h00_0001;
      lineLowCnt <= motionLineIn ? 24'h00_0000 : lineLowCnt + 24'h00_0001;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence low_held_s;
    !motionLineIn[*3] ##1 (hibernating && bootStrapSelect && !motionLineIn);
  endsequence
  boot_pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(motionLineOe_n) && !active |-> oeLowCnt >= BOOT_CYC - 60 && oeLowCnt <= BOOT_CYC + 60)
    else $error("boot pulse length wrong");
  mot_pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(motionLineOe_n) && active |-> oeLowCnt >= MOT_CYC - 60 && oeLowCnt <= MOT_CYC + 60)
    else $error("motion pulse length wrong");
  motion_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(motionLineOe_n) && $past(active) |-> $past(exceedNow))
    else $error("motion pulse without exceeding sample");
  thr_table_a: assert property (@(posedge sys_clk) disable iff (rst)
    upperThr == (thrSelect == OWM_SEL_ONE ? 12'h020 : thrSelect == OWM_SEL_TWO ? 12'h060 :
    thrSelect == OWM_SEL_THREE ? 12'h080 : 12'h040)) else $error("upper threshold wrong");
  thr_sym_a: assert property (@(posedge sys_clk) disable iff (rst)
    lowerThr == -upperThr) else $error("lower threshold wrong");
  hib_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    low_held_s |=> hibernating) else $error("left hibernate without line rise");
  hib_entry_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(hibernating) && $past(active) && !$past(deepSleepReq) && !$past(deepSleepReq, 2)
    |-> lineLowCnt >= HIB_CYC - 60) else $error("hibernate entered too early");
  hib_released_a: assert property (@(posedge sys_clk) disable iff (rst)
    hibernating |-> motionLineOe_n && !active) else $error("line driven or active in hibernate");
  line_pin_fixed_a: assert property (@(posedge sys_clk) disable iff (rst)
    motionLineOut == 1'b0 && lineInEnable && (bootOutEnable || !bootStrapSelect))
    else $error("pin functions wrong");
endmodule // owm_motion_top_assertions

bind owm_motion_top owm_motion_top_assertions #(.BOOT_PULSE_US(BOOT_PULSE_US), .WINDOW_US(WINDOW_US),
  .MOT_PULSE_US(MOT_PULSE_US), .HIB_DELAY_US(HIB_DELAY_US), .DEBOUNCE(DEBOUNCE)) owm_chk_inst (
  .sys_clk, .rst, .motionLineIn, .motionLineOut, .motionLineOe_n, .bootStrapSelect, .deepSleepReq,
  .sampleValid, .sampleVal, .active, .hibernating, .lineInEnable, .bootOutEnable, .thrSelect,
  .upperThr, .lowerThr);

// >>> test/owm_motion_top_tb.sv
// self-checking bench of the one-wire motion block
`timescale 1ns/1ps
module owm_motion_top_tb import owm_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic csWakeIn = 1'b0;
  logic deepSleepReq = 1'b0;
  logic activeSet = 1'b0;
  logic activeClr = 1'b0;
  logic sampleValid = 1'b0;
  logic signed [11:0] sampleVal = 12'h000;
  logic lineA, oeA_n, actA, hibA, oeB_n, actB, hibB;
  logic outA, outB, lieA, lieB, boeA, boeB;
  logic strapA = 1'b1;
  logic strapB = 1'b1;
  owm_sel_e selA, selB;
  logic signed [11:0] upA, loA, upB, loB;
  logic [31:0] rng = 32'h0000_0057;
  int nMismatch = 0;
  int samplesChecked = 0;
  int cycles = 0;
  // ---------------------------------------------------------------
  // design, host and clock
  // ---------------------------------------------------------------
  owm_motion_top #(.BOOT_PULSE_US(10), .WINDOW_US(600), .MOT_PULSE_US(10), .HIB_DELAY_US(10)) owm_motion_top_inst (
    .sys_clk(sys_clk), .rst(rst), .motionLineIn(lineA), .motionLineOut(outA), .motionLineOe_n(oeA_n),
    .bootStrapSelect(strapA), .csWakeIn(csWakeIn), .deepSleepReq(deepSleepReq), .activeSet(activeSet),
    .activeClr(activeClr), .sampleValid(sampleValid), .sampleVal(sampleVal), .active(actA), .hibernating(hibA),
    .lineInEnable(lieA), .bootOutEnable(boeA), .thrSelect(selA), .upperThr(upA), .lowerThr(loA));
  // second device, line always pulled up
  owm_motion_top #(.BOOT_PULSE_US(10), .WINDOW_US(20), .MOT_PULSE_US(10), .HIB_DELAY_US(10)) owm_motion_top_inst_b (
    .sys_clk(sys_clk), .rst(rst), .motionLineIn(oeB_n), .motionLineOut(outB), .motionLineOe_n(oeB_n),
    .bootStrapSelect(strapB), .csWakeIn(csWakeIn), .deepSleepReq(deepSleepReq), .activeSet(activeSet),
    .activeClr(activeClr), .sampleValid(sampleValid), .sampleVal(sampleVal), .active(actB), .hibernating(hibB),
    .lineInEnable(lieB), .bootOutEnable(boeB), .thrSelect(selB), .upperThr(upB), .lowerThr(loB));
  owm_host_model owm_host_model_inst (.sys_clk(sys_clk), .devOe_n(oeA_n), .lineLevel(lineA));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 95000) begin
      nMismatch++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic over(input logic signed [11:0] v, input logic signed [11:0] thr);
    return v > thr || v < -thr;
  endfunction
  task automatic end_of_test();
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic sample(input logic b, input logic signed [11:0] v, input logic signed [11:0] thr);
    int n;
    n = 0;
    sampleVal = v;
    sampleValid = 1'b1;
    step(1);
    sampleValid = 1'b0;
    step(2);
    chk("motion pulse", {11'h000, !over(v, thr)}, {11'h000, b ? oeB_n : oeA_n});
    while (!(b ? oeB_n : oeA_n) && n < 2000) begin
      step(1);
      n++;
    end
    step(1);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic signed [11:0] corn [4];
    int n;
    corn = '{12'h040, 12'h041, 12'hfc0, 12'hfbf};
    n = 0;
    step(5);
    rst = 1'b0;
    step(1300);
    chk("hib after boot", 12'h001, {11'h000, hibA});
    chk("auto active", 12'h001, {11'h000, actB});
    chk("boot out en", 12'h001, {11'h000, boeA});
    chk("line in en", 12'h001, {11'h000, lieA});
    chk("drive data", 12'h000, {11'h000, outA});
    csWakeIn = 1'b1;
    step(20);
    csWakeIn = 1'b0;
    step(20);
    chk("cs wake", 12'h001, {11'h000, hibA});
    step(2000);
    chk("default sel", {10'h000, OWM_SEL_DEF}, {10'h000, selB});
    chk("default upper", 12'h040, upB);
    chk("default lower", 12'hfc0, loB);
    foreach (corn[i]) sample(1'b1, corn[i], 12'h040);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      sample(1'b1, {{3{rng[8]}}, rng[8:0]}, 12'h040);
    end
    activeClr = 1'b1;
    step(1);
    activeClr = 1'b0;
    step(2);
    chk("active clear", 12'h000, {11'h000, actB});
    sample(1'b1, 12'h100, 12'h7ff);
    activeSet = 1'b1;
    step(1);
    activeSet = 1'b0;
    step(2);
    chk("active set", 12'h001, {11'h000, actB});
    deepSleepReq = 1'b1;
    step(1);
    deepSleepReq = 1'b0;
    step(3);
    chk("deep sleep", 12'h001, {11'h000, hibB});
    rng = xs(rng);
    owm_host_model_inst.sel_pulse(565 + int'(rng[3:0]));
    while (selA === OWM_SEL_DEF && n < 3000) begin
      step(1);
      n++;
    end
    step(5);
    chk("sel one", {10'h000, OWM_SEL_ONE}, {10'h000, selA});
    chk("sel upper", 12'h020, upA);
    chk("sel lower", 12'hfe0, loA);
    sample(1'b0, 12'h020, 12'h020);
    sample(1'b0, 12'h021, 12'h020);
    sample(1'b0, 12'hfdf, 12'h020);
    owm_host_model_inst.drive_low(1'b1);
    step(500);
    owm_host_model_inst.drive_low(1'b0);
    step(20);
    chk("short low", 12'h000, {11'h000, hibA});
    owm_host_model_inst.drive_low(1'b1);
    step(1150);
    chk("forced hib", 12'h001, {11'h000, hibA});
    chk("hib inactive", 12'h000, {11'h000, actA});
    strapB = 1'b0;
    rst = 1'b1;
    step(5);
    rst = 1'b0;
    step(100);
    chk("boot drive", 12'h000, {11'h000, oeB_n});
    chk("boot out en b", 12'h001, {11'h000, boeB});
    step(1100);
    chk("strap low run", 12'h000, {11'h000, hibB});
    chk("strap low idle", 12'h000, {11'h000, actB});
    chk("boot out off", 12'h000, {11'h000, boeB});
    chk("hib line low", 12'h001, {11'h000, hibA});
    chk("line in en b", 12'h001, {11'h000, lieB});
    chk("drive data b", 12'h000, {11'h000, outB});
    deepSleepReq = 1'b1;
    step(1);
    deepSleepReq = 1'b0;
    step(3);
    chk("sleep strap low", 12'h001, {11'h000, hibB});
    csWakeIn = 1'b1;
    step(10);
    csWakeIn = 1'b0;
    chk("cs wakes", 12'h000, {11'h000, hibB});
    chk("cs ignored", 12'h001, {11'h000, hibA});
    end_of_test();
  end
endmodule // owm_motion_top_tb
